// file: rtl/nvd_dispatch.sv
// interrupt acknowledge, non-maskable path and vector dispatch with apb registers
// Functional notes
// - simultaneous maskable: lowest priority number wins
// - sources 23-39 code 0230H..0330H, zero-extended handler
// - divide in progress saves its own address
// - illegal opcode: saved address plus 4
// - other events save the next address
// - non-maskable ignores disable, beats maskable
// - pin edge enabled by edge bits requests
// - watchdog non-maskable only when select is 1
// - hold non-maskable while in-service flag set
// - repeated non-maskable requests merge into one
// - save pc and status to fatal saves
// - cause upper half 0010H pin, 0020H watchdog
// - entry sets in-service, disable; clears in-progress
// - vector to 00000010H or 00000020H
// - variant-only sources never assert when absent
// - status bits 7,6,5; reset 00000020H
// - edge enable bit 0, both reset to 0
//
// Design decisions made here: the register addresses and the APB register port.
module nvd_dispatch #(
  parameter int NUM_SRC     = 40,
  parameter bit HAS_SERIAL2 = 1'b1,
  parameter bit HAS_AUTOBUS = 1'b1
) (
  // clock and reset
  input  wire logic               CORE_CLK,
  input  wire logic               RESETN,
  // apb slave
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  // event sources
  input  wire logic               NMI_PIN,
  input  wire logic               WDT_OVF,
  input  wire logic [NUM_SRC-1:0] MASK_REQ,
  // core
  input  wire logic [31:0]        CORE_PC,
  input  wire logic [31:0]        CORE_NEXT_PC,
  input  wire logic               CORE_DIVIDE_BUSY,
  input  wire logic               CORE_ILLEGAL,
  output logic                    VEC_VALID,
  output logic      [31:0]        VEC_ADDR,
  output logic      [NUM_SRC-1:0] MASK_ACK
);
  typedef enum logic [4:0] {
    SEL_NONE = 5'h01,
    SEL_PIN  = 5'h02,
    SEL_WDT  = 5'h04,
    SEL_ILL  = 5'h08,
    SEL_MASK = 5'h10
  } nvd_sel_e;

  if (NUM_SRC < 40 || NUM_SRC > 64) begin : g_bad_cfg
    $error("NUM_SRC must be 40 to 64");
  end

  logic               rst_s1;
  logic               rst_n;
  logic               rise_en;
  logic               fall_en;
  logic [7:0]         wdt_mode;
  logic [31:0]        program_status_word;
  logic [31:0]        fatal_pc_save;
  logic [31:0]        fatal_status_save;
  logic [31:0]        exception_cause_reg;
  logic [31:0]        maskable_pc_save;
  logic [31:0]        maskable_status_save;
  logic               wdt_mask_pend;
  logic [NUM_SRC-1:0] avail;
  logic [NUM_SRC-1:0] eff_req;
  logic [5:0]         next_win;
  logic               next_found;
  nvd_sel_e           next_sel;
  logic [31:0]        restored;
  logic [15:0]        win_code;
  logic               wr_en;
  logic               mapped;
  logic               nonmask_in_service_flag;
  logic               interrupt_disable_flag;
  nvd_nmi_if          nmi ();

  // reset release through two flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  nvd_nmi_det u_det (
    .clk   (CORE_CLK),
    .rst_n (rst_n),
    .pin   (NMI_PIN),
    .nmi   (nmi)
  );

  assign nonmask_in_service_flag = program_status_word[nvd_pkg::NMI_SVC_BIT];
  assign interrupt_disable_flag  = program_status_word[nvd_pkg::INT_DIS_BIT];
  assign nmi.rise_en = rise_en;
  assign nmi.fall_en = fall_en;
  assign nmi.wdt_evt = WDT_OVF & wdt_mode[nvd_pkg::WDT_SEL_BIT];
  assign nmi.ack_pin = (next_sel == SEL_PIN);
  assign nmi.ack_wdt = (next_sel == SEL_WDT);

  // variant-only sources are gated off
  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_avail
      if (i == nvd_pkg::SRC_SERIAL2) begin : g_s2
        assign avail[i] = HAS_SERIAL2;
      end else if (i == nvd_pkg::SRC_AUTOBUS_A || i == nvd_pkg::SRC_AUTOBUS_B) begin : g_ab
        assign avail[i] = HAS_AUTOBUS;
      end else begin : g_on
        assign avail[i] = 1'b1;
      end
    end
  endgenerate

  always_comb begin
    eff_req = MASK_REQ & avail;
    eff_req[nvd_pkg::SRC_WDT] = MASK_REQ[nvd_pkg::SRC_WDT] | wdt_mask_pend;
  end

  // lowest index wins
  always_comb begin
    next_win   = 6'h00;
    next_found = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (eff_req[i]) begin
        next_win   = 6'(i);
        next_found = 1'b1;
      end
    end
  end

  // code table: sources 0-7 from 0080H, the rest from 0140H
  always_comb begin
    if (next_win < 6'(nvd_pkg::LOW_GROUP)) begin
      win_code = nvd_pkg::CODE_MASK_LOW + 16'(next_win) * nvd_pkg::CODE_STEP;
    end else begin
      win_code = nvd_pkg::CODE_MASK_HIGH
               + 16'(next_win - 6'(nvd_pkg::LOW_GROUP)) * nvd_pkg::CODE_STEP;
    end
  end

  // one entry per cycle, none in the cycle after an entry
  always_comb begin
    if (VEC_VALID) begin
      next_sel = SEL_NONE;
    end else if (nmi.pend_pin && !nonmask_in_service_flag) begin
      next_sel = SEL_PIN;
    end else if (nmi.pend_wdt && !nonmask_in_service_flag) begin
      next_sel = SEL_WDT;
    end else if (CORE_ILLEGAL) begin
      next_sel = SEL_ILL;
    end else if (next_found && !interrupt_disable_flag && !nonmask_in_service_flag) begin
      next_sel = SEL_MASK;
    end else begin
      next_sel = SEL_NONE;
    end
  end

  always_comb begin
    if (next_sel == SEL_ILL) begin
      restored = CORE_PC + nvd_pkg::ILLEGAL_OFFSET;
    end else if (CORE_DIVIDE_BUSY) begin
      restored = CORE_PC;
    end else begin
      restored = CORE_NEXT_PC;
    end
  end

  // vector output and acknowledge
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      VEC_VALID <= 1'b0;
      VEC_ADDR  <= 32'h0000_0000;
      MASK_ACK  <= '0;
    end else begin
      VEC_VALID <= (next_sel != SEL_NONE);
      MASK_ACK  <= '0;
      case (next_sel)
        SEL_PIN:  VEC_ADDR <= {16'h0000, nvd_pkg::CODE_NMI_PIN};
        SEL_WDT:  VEC_ADDR <= {16'h0000, nvd_pkg::CODE_NMI_WDT};
        SEL_ILL:  VEC_ADDR <= {16'h0000, nvd_pkg::CODE_ILLEGAL};
        SEL_MASK: begin
          VEC_ADDR <= {16'h0000, win_code};
          MASK_ACK[next_win] <= 1'b1;
        end
        default:  VEC_ADDR <= VEC_ADDR;
      endcase
    end
  end

  // context save
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      fatal_pc_save        <= 32'h0000_0000;
      fatal_status_save    <= 32'h0000_0000;
      exception_cause_reg  <= 32'h0000_0000;
      maskable_pc_save     <= 32'h0000_0000;
      maskable_status_save <= 32'h0000_0000;
    end else if (next_sel == SEL_PIN || next_sel == SEL_WDT) begin
      fatal_pc_save       <= restored;
      fatal_status_save   <= program_status_word;
      exception_cause_reg[31:16] <= (next_sel == SEL_PIN) ? nvd_pkg::CODE_NMI_PIN
                                                          : nvd_pkg::CODE_NMI_WDT;
    end else if (next_sel == SEL_ILL || next_sel == SEL_MASK) begin
      maskable_pc_save     <= restored;
      maskable_status_save <= program_status_word;
      exception_cause_reg[15:0] <= (next_sel == SEL_ILL) ? nvd_pkg::CODE_ILLEGAL : win_code;
    end
  end

  // status word; entry wins over a software write
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      program_status_word <= nvd_pkg::PSW_RESET;
    end else if (next_sel == SEL_PIN || next_sel == SEL_WDT) begin
      program_status_word[nvd_pkg::NMI_SVC_BIT]  <= 1'b1;
      program_status_word[nvd_pkg::INT_DIS_BIT]  <= 1'b1;
      program_status_word[nvd_pkg::EXC_PROG_BIT] <= 1'b0;
    end else if (next_sel != SEL_NONE) begin
      program_status_word[nvd_pkg::INT_DIS_BIT]  <= 1'b1;
      program_status_word[nvd_pkg::EXC_PROG_BIT] <= 1'b0;
    end else if (wr_en && PADDR == nvd_pkg::OFF_PSW) begin
      program_status_word <= {24'h000000, PWDATA[nvd_pkg::PSW_W-1:0]};
    end
  end

  // maskable watchdog latch
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wdt_mask_pend <= 1'b0;
    end else if (WDT_OVF && !wdt_mode[nvd_pkg::WDT_SEL_BIT]) begin
      wdt_mask_pend <= 1'b1;
    end else if (next_sel == SEL_MASK && next_win == 6'(nvd_pkg::SRC_WDT)) begin
      wdt_mask_pend <= 1'b0;
    end
  end

  // apb slave: zero wait, read data captured in setup
  assign wr_en   = PSEL & PENABLE & PWRITE & mapped;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign mapped  = (PADDR[1:0] == 2'b00) && (PADDR <= nvd_pkg::OFF_PENDING);

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rise_en  <= 1'b0;
      fall_en  <= 1'b0;
      wdt_mode <= 8'h00;
    end else if (wr_en) begin
      if (PADDR == nvd_pkg::OFF_RISE_EN) rise_en <= PWDATA[0];
      if (PADDR == nvd_pkg::OFF_FALL_EN) fall_en <= PWDATA[0];
      if (PADDR == nvd_pkg::OFF_WDT_MODE) wdt_mode <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        nvd_pkg::OFF_RISE_EN:   PRDATA <= {31'h0, rise_en};
        nvd_pkg::OFF_FALL_EN:   PRDATA <= {31'h0, fall_en};
        nvd_pkg::OFF_WDT_MODE:  PRDATA <= {24'h0, wdt_mode};
        nvd_pkg::OFF_PSW:       PRDATA <= program_status_word;
        nvd_pkg::OFF_FATAL_PC:  PRDATA <= fatal_pc_save;
        nvd_pkg::OFF_FATAL_PSW: PRDATA <= fatal_status_save;
        nvd_pkg::OFF_CAUSE:     PRDATA <= exception_cause_reg;
        nvd_pkg::OFF_MASK_PC:   PRDATA <= maskable_pc_save;
        nvd_pkg::OFF_MASK_PSW:  PRDATA <= maskable_status_save;
        nvd_pkg::OFF_PENDING:   PRDATA <= {30'h0, nmi.pend_wdt, nmi.pend_pin};
        default:                PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n);

  sequence nmi_taken_s;
    (next_sel == SEL_PIN) || (next_sel == SEL_WDT);
  endsequence

  sequence nmi_entered_s;
    VEC_VALID && nonmask_in_service_flag && interrupt_disable_flag
      && !program_status_word[nvd_pkg::EXC_PROG_BIT];
  endsequence

  lowest_wins_a: assert property ((next_sel == SEL_MASK) |=>
    ((MASK_ACK - 1'b1) & $past(eff_req)) == '0 && $onehot(MASK_ACK))
    else $error("maskable acknowledge not the lowest requester");
  mask_vector_a: assert property (|MASK_ACK |->
    VEC_ADDR == {16'h0000, exception_cause_reg[15:0]})
    else $error("maskable vector differs from cause code");
  divide_save_a: assert property ((next_sel != SEL_NONE && next_sel != SEL_ILL
    && CORE_DIVIDE_BUSY) |=> (fatal_pc_save == $past(CORE_PC)
    || maskable_pc_save == $past(CORE_PC)))
    else $error("divide return address wrong");
  illegal_save_a: assert property ((next_sel == SEL_ILL) |=>
    maskable_pc_save - nvd_pkg::ILLEGAL_OFFSET == $past(CORE_PC))
    else $error("illegal opcode return address wrong");
  next_save_a: assert property ((next_sel == SEL_MASK && !CORE_DIVIDE_BUSY) |=>
    maskable_pc_save == $past(CORE_NEXT_PC))
    else $error("maskable return address wrong");
  nmi_beats_mask_a: assert property ((nmi.pend_pin && !nonmask_in_service_flag && !VEC_VALID) |=>
    VEC_ADDR == 32'h0000_0010 && MASK_ACK == '0)
    else $error("pin request not vectored first");
  nmi_held_a: assert property (nonmask_in_service_flag |-> !nmi.ack_pin && !nmi.ack_wdt)
    else $error("non-maskable taken while in service");
  nmi_entry_a: assert property (nmi_taken_s |=> nmi_entered_s
    ##0 fatal_status_save == $past(program_status_word))
    else $error("non-maskable entry state wrong");
  wdt_cause_a: assert property ((next_sel == SEL_WDT) |=>
    exception_cause_reg[31:16] == 16'h0020 && VEC_ADDR == 32'h0000_0020)
    else $error("watchdog cause or vector wrong");
  wdt_route_a: assert property ((WDT_OVF && !wdt_mode[nvd_pkg::WDT_SEL_BIT]) |=>
    wdt_mask_pend)
    else $error("maskable watchdog not latched");
  absent_src_a: assert property ((MASK_ACK & ~avail) == '0)
    else $error("absent source acknowledged");
endmodule

// file: rtl/nvd_nmi_det.sv
// non-maskable pin synchroniser, edge select and sticky pending latches
module nvd_nmi_det (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin
  input  wire logic pin,
  // dispatcher side
  nvd_nmi_if.det    nmi
);
  logic sync1;
  logic sync2;
  logic prev;
  logic edge_hit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev  <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign edge_hit = (nmi.rise_en & sync2 & ~prev) | (nmi.fall_en & ~sync2 & prev);

  // set wins over acknowledge; repeats merge into one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi.pend_pin <= 1'b0;
    end else if (edge_hit) begin
      nmi.pend_pin <= 1'b1;
    end else if (nmi.ack_pin) begin
      nmi.pend_pin <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi.pend_wdt <= 1'b0;
    end else if (nmi.wdt_evt) begin
      nmi.pend_wdt <= 1'b1;
    end else if (nmi.ack_wdt) begin
      nmi.pend_wdt <= 1'b0;
    end
  end

  edge_sets_a: assert property (@(posedge clk) disable iff (!rst_n)
    edge_hit |=> nmi.pend_pin)
    else $error("detected pin edge did not set the pending latch");
endmodule

// file: rtl/nvd_nmi_if.sv
// carrier between the dispatcher and the non-maskable detector
interface nvd_nmi_if;
  logic rise_en;
  logic fall_en;
  logic wdt_evt;
  logic ack_pin;
  logic ack_wdt;
  logic pend_pin;
  logic pend_wdt;
  modport ctrl (output rise_en, fall_en, wdt_evt, ack_pin, ack_wdt,
                input  pend_pin, pend_wdt);
  modport det  (input  rise_en, fall_en, wdt_evt, ack_pin, ack_wdt,
                output pend_pin, pend_wdt);
endinterface

// file: rtl/nvd_pkg.sv
// package: offsets, status word layout, exception codes and handler addresses
package nvd_pkg;
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  OFF_RISE_EN    = 8'h00;
  localparam logic [7:0]  OFF_FALL_EN    = 8'h04;
  localparam logic [7:0]  OFF_WDT_MODE   = 8'h08;
  localparam logic [7:0]  OFF_PSW        = 8'h0c;
  localparam logic [7:0]  OFF_FATAL_PC   = 8'h10;
  localparam logic [7:0]  OFF_FATAL_PSW  = 8'h14;
  localparam logic [7:0]  OFF_CAUSE      = 8'h18;
  localparam logic [7:0]  OFF_MASK_PC    = 8'h1c;
  localparam logic [7:0]  OFF_MASK_PSW   = 8'h20;
  localparam logic [7:0]  OFF_PENDING    = 8'h24;
  localparam int          NMI_SVC_BIT    = 7;
  localparam int          EXC_PROG_BIT   = 6;
  localparam int          INT_DIS_BIT    = 5;
  localparam int          WDT_SEL_BIT    = 4;
  localparam int          PSW_W          = 8;
  localparam logic [31:0] PSW_RESET      = 32'h0000_0020;
  localparam logic [15:0] CODE_NMI_PIN   = 16'h0010;
  localparam logic [15:0] CODE_NMI_WDT   = 16'h0020;
  localparam logic [15:0] CODE_ILLEGAL   = 16'h0060;
  localparam logic [15:0] CODE_MASK_LOW  = 16'h0080;
  localparam logic [15:0] CODE_MASK_HIGH = 16'h0140;
  localparam logic [15:0] CODE_STEP      = 16'h0010;
  localparam int          LOW_GROUP      = 8;
  localparam int          SRC_SERIAL2    = 24;
  localparam int          SRC_AUTOBUS_A  = 29;
  localparam int          SRC_AUTOBUS_B  = 30;
  localparam int          SRC_WDT        = 0;
  localparam logic [31:0] ILLEGAL_OFFSET = 32'h0000_0004;
endpackage

// file: testbench/nvd_core_model.sv
// core pipeline model: program counter walk, vector load, held illegal opcode flag and registered divide flag
module nvd_core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // bench requests
  input  wire logic        ill_req,
  input  wire logic        div_req,
  // vector from the dispatcher
  input  wire logic        vec_valid,
  input  wire logic [31:0] vec_addr,
  // to the dispatcher
  output logic      [31:0] pc,
  output logic      [31:0] next_pc,
  output logic             divide_busy,
  output logic             illegal,
  // values seen at the last edge
  output logic      [31:0] last_pc,
  output logic      [31:0] last_next
);
  timeunit 1ns;
  timeprecision 1ps;
  assign next_pc = pc + 32'h0000_0004;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc        <= 32'h0000_1000;
      divide_busy <= 1'b0;
      illegal   <= 1'b0;
      last_pc   <= 32'h0000_0000;
      last_next <= 32'h0000_0000;
    end else begin
      pc        <= vec_valid ? vec_addr : next_pc;
      divide_busy <= div_req;
      illegal   <= ill_req | (illegal & ~vec_valid);
      last_pc   <= pc;
      last_next <= next_pc;
    end
  end
endmodule

// file: testbench/nvd_dispatch_bench.sv
// self-checking bench for the dispatcher driving a core pipeline model, checked against a code-table function and the model's addresses
module nvd_dispatch_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic        nmi_pin, wdt_ovf, ill_req, div_req, divide_busy, illegal, vec_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, vec_addr, core_pc, core_next, last_pc, last_next, ret;
  logic [39:0] mask_req, mask_ack;
  int          bad_count, tests_run, vec_count, c0, k, a, b, lo;
  integer      seed;

  nvd_dispatch dut (.CORE_CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .NMI_PIN(nmi_pin), .WDT_OVF(wdt_ovf), .MASK_REQ(mask_req),
    .CORE_PC(core_pc), .CORE_NEXT_PC(core_next), .CORE_DIVIDE_BUSY(divide_busy),
    .CORE_ILLEGAL(illegal), .VEC_VALID(vec_valid), .VEC_ADDR(vec_addr), .MASK_ACK(mask_ack));
  nvd_core_model core (.clk(clk), .rst_n(resetn), .ill_req(ill_req), .div_req(div_req),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .pc(core_pc), .next_pc(core_next),
    .divide_busy(divide_busy), .illegal(illegal), .last_pc(last_pc), .last_next(last_next));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (vec_valid === 1'b1) vec_count++;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check_val(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      bad_count++;
      finish_test();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wait_vec;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (vec_valid === 1'b1) break;
    end
    if (i == 50) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic pulse_wdt;
    @(posedge clk); wdt_ovf <= 1'b1;
    @(posedge clk); wdt_ovf <= 1'b0;
  endtask
  task automatic toggle_pin;
    @(posedge clk); nmi_pin <= 1'b0;
    repeat (4) @(posedge clk);
    nmi_pin <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [31:0] mcode(input int n);
    return (n < 8) ? 32'h80 + 32'(16 * n) : 32'h140 + 32'(16 * (n - 8));
  endfunction

  initial begin
    seed = 3;
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; nmi_pin = 1'b0; wdt_ovf = 1'b0; ill_req = 1'b0; div_req = 1'b0;
    mask_req = 40'h0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, nvd_pkg::OFF_PSW, 32'h0); check_val("status reset", 32'h20, rd);
    check_val("mapped no error", 0, er);
    apb(1'b0, nvd_pkg::OFF_RISE_EN, 32'h0); check_val("rise reset", 32'h0, rd);
    apb(1'b0, nvd_pkg::OFF_FALL_EN, 32'h0); check_val("fall reset", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0); check_val("unmapped error", 1, er);
    $display("test reset done");
    apb(1'b1, nvd_pkg::OFF_PSW, 32'h0);
    for (k = 0; k < 29; k++) begin
      a = (k < 17) ? 23 + k : $unsigned($random(seed)) % 40;
      b = (k < 17) ? a : $unsigned($random(seed)) % 40;
      lo = (a < b) ? a : b;
      @(posedge clk); mask_req <= (40'h1 << a) | (40'h1 << b);
      wait_vec();
      ret = last_next;
      mask_req <= 40'h0;
      check_val("maskable ack", 40'h1 << lo, mask_ack);
      check_val("maskable vector", mcode(lo), vec_addr);
      apb(1'b0, nvd_pkg::OFF_MASK_PC, 32'h0); check_val("maskable save", ret, rd);
      apb(1'b1, nvd_pkg::OFF_PSW, 32'h0);
    end
    $display("test maskable done");
    apb(1'b1, nvd_pkg::OFF_RISE_EN, 32'h1);
    @(posedge clk); nmi_pin <= 1'b1;
    repeat (3) @(posedge clk);
    mask_req <= 40'h1 << 5;
    wait_vec();
    ret = last_next;
    check_val("pin vector", 32'h10, vec_addr);
    check_val("pin no ack", 40'h0, mask_ack);
    apb(1'b0, nvd_pkg::OFF_PSW, 32'h0); check_val("entry status", 32'ha0, rd);
    apb(1'b0, nvd_pkg::OFF_FATAL_PC, 32'h0); check_val("fatal pc", ret, rd);
    apb(1'b0, nvd_pkg::OFF_FATAL_PSW, 32'h0); check_val("fatal status", 32'h0, rd);
    apb(1'b0, nvd_pkg::OFF_CAUSE, 32'h0); check_val("pin cause", 32'h10, rd >> 16);
    $display("test pin done");
    apb(1'b1, nvd_pkg::OFF_WDT_MODE, 32'h10);
    c0 = vec_count;
    pulse_wdt(); toggle_pin(); pulse_wdt(); toggle_pin();
    check_val("held entries", 0, vec_count - c0);
    apb(1'b0, nvd_pkg::OFF_PENDING, 32'h0); check_val("pending", 32'h3, rd);
    apb(1'b1, nvd_pkg::OFF_PSW, 32'h0);
    wait_vec(); check_val("pin first", 32'h10, vec_addr);
    apb(1'b1, nvd_pkg::OFF_PSW, 32'h0);
    wait_vec(); check_val("watchdog vector", 32'h20, vec_addr);
    apb(1'b0, nvd_pkg::OFF_CAUSE, 32'h0); check_val("wdt cause", 32'h20, rd >> 16);
    repeat (10) @(posedge clk);
    check_val("merged entries", 2, vec_count - c0);
    apb(1'b1, nvd_pkg::OFF_PSW, 32'h0);
    wait_vec(); check_val("held maskable", mcode(5), vec_addr);
    mask_req <= 40'h0;
    $display("test merge done");
    apb(1'b1, nvd_pkg::OFF_WDT_MODE, 32'h0);
    apb(1'b1, nvd_pkg::OFF_PSW, 32'h0);
    pulse_wdt(); wait_vec();
    check_val("wdt maskable", 32'h80, vec_addr);
    check_val("wdt ack", 40'h1, mask_ack);
    apb(1'b1, nvd_pkg::OFF_PSW, 32'h0);
    @(posedge clk); div_req <= 1'b1;
    repeat (2) @(posedge clk);
    mask_req <= 40'h1 << 9;
    wait_vec();
    ret = last_pc;
    mask_req <= 40'h0; div_req <= 1'b0;
    apb(1'b0, nvd_pkg::OFF_MASK_PC, 32'h0); check_val("divide save", ret, rd);
    @(posedge clk); ill_req <= 1'b1;
    @(posedge clk); ill_req <= 1'b0;
    wait_vec();
    ret = last_pc + 32'h4;
    check_val("illegal vector", 32'h60, vec_addr);
    apb(1'b0, nvd_pkg::OFF_MASK_PC, 32'h0); check_val("illegal save", ret, rd);
    $display("test core events done");
    apb(1'b1, nvd_pkg::OFF_RISE_EN, 32'h0);
    apb(1'b1, nvd_pkg::OFF_FALL_EN, 32'h1);
    @(posedge clk); nmi_pin <= 1'b0;
    wait_vec(); check_val("falling vector", 32'h10, vec_addr);
    $display("test falling edge done");
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule
